// ---- verilog/vmsc_top.sv ----
// vmsc_top: samples a converter result every 0.5 s, shows it in volts
// on four scanned seven-segment digits, registers over AXI4-Lite
// assumes the converter raises adc_done for a cycle when a result is
// valid on adc_result, and an external 2-to-4 decoder on digit_select
//
// The AXI4-Lite slave port and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module vmsc_top
  import vmsc_pkg::*;
#(
  parameter int SAMPLE_N = SAMPLE_CYCLES,  // cycles per sampling tick
  parameter int SCAN_N   = SCAN_CYCLES     // cycles per scan step
)(
  input  wire logic        mclk,           // system clock
  input  wire logic        rst,            // async reset, high
  input  wire logic [3:0]  s_axi_awaddr,   // write address
  input  wire logic        s_axi_awvalid,  // write address valid
  output logic             s_axi_awready,  // write address ready
  input  wire logic [31:0] s_axi_wdata,    // write data
  input  wire logic [3:0]  s_axi_wstrb,    // write strobes
  input  wire logic        s_axi_wvalid,   // write data valid
  output logic             s_axi_wready,   // write data ready
  output logic [1:0]       s_axi_bresp,    // write response
  output logic             s_axi_bvalid,   // write response valid
  input  wire logic        s_axi_bready,   // write response ready
  input  wire logic [3:0]  s_axi_araddr,   // read address
  input  wire logic        s_axi_arvalid,  // read address valid
  output logic             s_axi_arready,  // read address ready
  output logic [31:0]      s_axi_rdata,    // read data
  output logic [1:0]       s_axi_rresp,    // read response
  output logic             s_axi_rvalid,   // read data valid
  input  wire logic        s_axi_rready,   // read data ready
  output logic             adc_start,      // conversion start pulse
  output logic [2:0]       analog_channel, // channel select, always zero
  input  wire logic        adc_done,       // conversion finished pulse
  input  wire logic [15:0] adc_result,     // left-justified result word
  output logic [7:0]       segment_out,    // segments, high lights
  output logic [1:0]       digit_select    // decoder select
);

  // segment table lookup
  function automatic logic [7:0] vmsc_seg(input logic [3:0] d);
    case (d)
      4'h0: vmsc_seg = SEG_0;
      4'h1: vmsc_seg = SEG_1;
      4'h2: vmsc_seg = SEG_2;
      4'h3: vmsc_seg = SEG_3;
      4'h4: vmsc_seg = SEG_4;
      4'h5: vmsc_seg = SEG_5;
      4'h6: vmsc_seg = SEG_6;
      4'h7: vmsc_seg = SEG_7;
      4'h8: vmsc_seg = SEG_8;
      4'h9: vmsc_seg = SEG_9;
      default: vmsc_seg = SEG_BLANK;
    endcase
  endfunction

  typedef enum logic [0:0] {VMSC_IDLE, VMSC_BUSY} vmsc_conv_type;

  logic [SAMPLE_CNT_W-1:0] samp_cnt_reg, samp_cnt_next;
  logic [SCAN_CNT_W-1:0]   scan_cnt_reg, scan_cnt_next;
  logic                    sample_tick, scan_tick, take;
  vmsc_conv_type           conv_reg, conv_next;
  logic                    done_seen_reg, done_seen_next;
  logic                    start_reg, start_next;
  logic [15:0]             word_reg, word_next;
  logic [9:0]              code_reg, code_next;
  logic [9:0]              volts_reg, volts_next;
  vmsc_disp_type           disp_reg, disp_next;
  logic [1:0]              sel_reg, sel_next;
  logic [7:0]              seg_reg, seg_next;
  logic [0:0]              ctrl_reg, ctrl_next;
  logic [18:0]             prod;
  logic [9:0]              new_code, new_volts;

  // tick counters; periods are parameters so a bench can shorten them
  assign sample_tick = (samp_cnt_reg ==
                        SAMPLE_CNT_W'(SAMPLE_N - 1));
  assign scan_tick   = (scan_cnt_reg ==
                        SCAN_CNT_W'(SCAN_N - 1));
  // a done landing on the tick itself is taken there, else the next
  // start would overwrite the result before it is ever read
  assign take        = sample_tick && (done_seen_reg
                       || (conv_reg == VMSC_BUSY && adc_done));

  // code extraction and scaling of the incoming word
  assign new_code  = 10'((adc_result >> CODE_SHIFT)
                         & CODE_MASK);
  assign prod      = {9'h0, code_reg} * SCALE_MUL;
  assign new_volts = {1'b0, prod[18:SCALE_SH]};

  // sampling, conversion and display update
  always_comb
  begin
    samp_cnt_next  = sample_tick ? '0 : samp_cnt_reg + 1'b1;
    conv_next      = conv_reg;
    done_seen_next = done_seen_reg;
    start_next     = 1'b0;
    word_next      = word_reg;
    code_next      = code_reg;
    disp_next      = disp_reg;
    // completion is only remembered; no interrupt-like reaction to it
    if (conv_reg == VMSC_BUSY && adc_done)
    begin
      done_seen_next = 1'b1;
      conv_next      = VMSC_IDLE;
    end
    if (take)
    begin
      word_next      = adc_result;
      code_next      = new_code;
      done_seen_next = 1'b0;
    end
    if (sample_tick && ctrl_reg[CTRL_EN] && conv_next == VMSC_IDLE)
    begin
      start_next = 1'b1;
      conv_next  = VMSC_BUSY;
    end
    // patterns follow the registered volts; replaced as one word
    disp_next.pat[TOP_POS] = (volts_reg / 10'd1000 == 10'd0) ? SEG_BLANK
                           : vmsc_seg(4'(volts_reg / 10'd1000));
    disp_next.pat[UNITS_POS] = vmsc_seg(4'((volts_reg / 10'd100) % 10'd10))
                             | SEG_DP;
    disp_next.pat[1] = vmsc_seg(4'((volts_reg / 10'd10) % 10'd10));
    disp_next.pat[0] = vmsc_seg(4'(volts_reg % 10'd10));
    volts_next = new_volts;
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      samp_cnt_reg  <= '0;
      conv_reg      <= VMSC_IDLE;
      done_seen_reg <= 1'b0;
      start_reg     <= 1'b0;
      word_reg      <= 16'h0000;
      code_reg      <= 10'h000;
      volts_reg     <= 10'h000;
      disp_reg      <= DISP_RST;
    end
    else
    begin
      samp_cnt_reg  <= samp_cnt_next;
      conv_reg      <= conv_next;
      done_seen_reg <= done_seen_next;
      start_reg     <= start_next;
      word_reg      <= word_next;
      code_reg      <= code_next;
      volts_reg     <= volts_next;
      disp_reg      <= disp_next;
    end
  end

  // digit scan; segments follow the select so both change together
  always_comb
  begin
    scan_cnt_next = scan_tick ? '0 : scan_cnt_reg + 1'b1;
    sel_next      = scan_tick ? sel_reg + 2'h1 : sel_reg;
    seg_next      = disp_reg.pat[sel_next];
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      scan_cnt_reg <= '0;
      sel_reg      <= 2'h0;
      seg_reg      <= SEG_BLANK;
    end
    else
    begin
      scan_cnt_reg <= scan_cnt_next;
      sel_reg      <= sel_next;
      seg_reg      <= seg_next;
    end
  end

  assign adc_start      = start_reg;
  assign analog_channel = 3'h0;
  assign segment_out    = seg_reg;
  assign digit_select   = sel_reg;

  // axi4-lite slave, one write and one read in flight
  logic        aw_reg, aw_next, w_reg, w_next, bv_reg, bv_next;
  logic        rv_reg, rv_next;
  logic [3:0]  awa_reg, awa_next;
  logic [31:0] wd_reg, wd_next, rd_reg, rd_next;
  logic [3:0]  ws_reg, ws_next;
  logic [1:0]  br_reg, br_next, rr_reg, rr_next;

  assign s_axi_awready = !aw_reg && !bv_reg;
  assign s_axi_wready  = !w_reg && !bv_reg;
  assign s_axi_arready = !rv_reg;

  always_comb
  begin
    aw_next = aw_reg;
    w_next = w_reg;
    awa_next = awa_reg;
    wd_next = wd_reg;
    ws_next = ws_reg;
    bv_next = bv_reg && !s_axi_bready;
    br_next = br_reg;
    rv_next = rv_reg && !s_axi_rready;
    rd_next = rd_reg;
    rr_next = rr_reg;
    ctrl_next = ctrl_reg;
    if (s_axi_awvalid && s_axi_awready)
    begin
      aw_next  = 1'b1;
      awa_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      w_next  = 1'b1;
      wd_next = s_axi_wdata;
      ws_next = s_axi_wstrb;
    end
    // write performed once both halves are held
    if (aw_reg && w_reg)
    begin
      aw_next = 1'b0;
      w_next  = 1'b0;
      bv_next = 1'b1;
      br_next = RESP_OKAY;
      case ({awa_reg[3:2], 2'b00})
        REG_CTRL:   if (ws_reg[0]) ctrl_next = wd_reg[0:0];
        REG_RESULT, REG_VOLTS, REG_DIGITS: br_next = RESP_OKAY;
        default:    br_next = RESP_SLVERR;
      endcase
    end
    if (s_axi_arvalid && s_axi_arready)
    begin
      rv_next = 1'b1;
      rr_next = RESP_OKAY;
      case ({s_axi_araddr[3:2], 2'b00})
        REG_CTRL:   rd_next = {31'h0, ctrl_reg};
        REG_RESULT: rd_next = {16'h0000, word_reg};
        REG_VOLTS:  rd_next = {22'h0, volts_reg};
        REG_DIGITS: rd_next = disp_reg.pat;
        default:
        begin
          rd_next = 32'h0000_0000;
          rr_next = RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      aw_reg <= 1'b0;
      w_reg <= 1'b0;
      bv_reg <= 1'b0;
      rv_reg <= 1'b0;
      awa_reg <= 4'h0;
      wd_reg <= 32'h0000_0000;
      ws_reg <= 4'h0;
      br_reg <= RESP_OKAY;
      rd_reg <= 32'h0000_0000;
      rr_reg <= RESP_OKAY;
      ctrl_reg <= CTRL_RST;
    end
    else
    begin
      aw_reg <= aw_next;
      w_reg <= w_next;
      bv_reg <= bv_next;
      rv_reg <= rv_next;
      awa_reg <= awa_next;
      wd_reg <= wd_next;
      ws_reg <= ws_next;
      br_reg <= br_next;
      rd_reg <= rd_next;
      rr_reg <= rr_next;
      ctrl_reg <= ctrl_next;
    end
  end

  assign s_axi_bvalid = bv_reg;
  assign s_axi_bresp  = br_reg;
  assign s_axi_rvalid = rv_reg;
  assign s_axi_rdata  = rd_reg;
  assign s_axi_rresp  = rr_reg;

  // checks on the design's own registers and outputs
  default clocking vmsc_cb @(posedge mclk); endclocking
  default disable iff (rst);

  AST_START_ON_TICK: assert property (
    sample_tick && ctrl_reg[CTRL_EN] && !(conv_reg == VMSC_BUSY && !adc_done)
    |=> adc_start && !$past(adc_start)) else $error("no start on tick");
  AST_EXTRACT: assert property (
    take |=> code_reg == $past(adc_result[15:6])) else $error("bad code");
  AST_SCALE: assert property (
    $changed(code_reg) |=>
      int'(volts_reg) * 1024 <= int'($past(code_reg)) * 330
      && int'($past(code_reg)) * 330 < (int'(volts_reg) + 1) * 1024)
    else $error("bad scaling");
  AST_RANGE: assert property (
    volts_reg <= FULL_SCALE) else $error("volts over full scale");
  AST_BLANK: assert property (
    volts_reg < 10'd1000 |=> disp_reg.pat[TOP_POS] == SEG_BLANK)
    else $error("top digit not blank");
  AST_POINT: assert property (
    disp_reg.pat[UNITS_POS][7] && !disp_reg.pat[1][7] && !disp_reg.pat[0][7])
    else $error("decimal point misplaced");
  AST_SCAN_HOLD: assert property (
    !scan_tick |=> $stable(digit_select)) else $error("select moved early");
  AST_SCAN_ORDER: assert property (
    scan_tick |=> digit_select == 2'($past(digit_select) + 2'h1))
    else $error("scan out of order");
  AST_SEG_TABLE: assert property (
    $changed(volts_reg) |=> disp_reg.pat[0] == vmsc_seg(4'($past(volts_reg)
                             % 10'd10))) else $error("bad units pattern");
  AST_SEG_OUT: assert property (
    $stable(disp_reg) && !$past(rst)
    |-> segment_out == disp_reg.pat[digit_select])
    else $error("segments not the lit digit");
  AST_TAKE_LATE: assert property (
    $changed(word_reg) |-> $past(sample_tick && (done_seen_reg || adc_done)))
    else $error("result taken off tick");
  AST_ATOMIC: assert property (
    $changed(disp_reg.pat[0]) |-> $changed(disp_reg.pat) ##0
    $past(volts_reg) != $past(volts_reg, 2)) else $error("stray update");

  COV_TAKE: cover property (take ##[1:4] $changed(disp_reg));
  COV_WRAP: cover property (scan_tick && digit_select == 2'h3);
  COV_AXI_WR: cover property (s_axi_bvalid && s_axi_bready);
  COV_AXI_RD: cover property (s_axi_rvalid && s_axi_rready
                              && s_axi_rresp == RESP_OKAY);

endmodule
`default_nettype wire

// ---- verilog/vmsc_pkg.sv ----
// vmsc_pkg: constants, register map and types of the voltmeter block
// assumes a 200 MHz mclk and a 32-bit AXI4-Lite register bus
package vmsc_pkg;

  // clock and timing
  localparam int CLK_PERIOD_NS    = 5;
  localparam int SAMPLE_PERIOD_NS = 500_000_000;             // 0.5 s
  localparam int SAMPLE_CYCLES    = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;
  localparam int SCAN_PERIOD_NS   = 3_276_800;               // 3.2768 ms
  localparam int SCAN_CYCLES      = SCAN_PERIOD_NS / CLK_PERIOD_NS;
  localparam int SAMPLE_CNT_W     = 27;
  localparam int SCAN_CNT_W       = 20;

  // result word layout
  localparam int          CODE_SHIFT = 6;
  localparam logic [15:0] CODE_MASK  = 16'h03ff;
  localparam logic [18:0] SCALE_MUL  = 19'h14a;              // 330
  localparam int          SCALE_SH   = 10;                   // divide by 1024
  localparam logic [9:0]  FULL_SCALE = 10'h14a;              // 3.30 V

  // segment patterns, bit 7 is the decimal point
  localparam logic [7:0] SEG_0     = 8'h3f;
  localparam logic [7:0] SEG_1     = 8'h06;
  localparam logic [7:0] SEG_2     = 8'h5b;
  localparam logic [7:0] SEG_3     = 8'h4f;
  localparam logic [7:0] SEG_4     = 8'h66;
  localparam logic [7:0] SEG_5     = 8'h6d;
  localparam logic [7:0] SEG_6     = 8'h7d;
  localparam logic [7:0] SEG_7     = 8'h27;
  localparam logic [7:0] SEG_8     = 8'h7f;
  localparam logic [7:0] SEG_9     = 8'h6f;
  localparam logic [7:0] SEG_BLANK = 8'h00;
  localparam logic [7:0] SEG_DP    = 8'h80;
  localparam int         UNITS_POS = 2;                      // volts digit
  localparam int         TOP_POS   = 3;

  // register map (byte addresses)
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_RESULT = 4'h4;
  localparam logic [3:0] REG_VOLTS  = 4'h8;
  localparam logic [3:0] REG_DIGITS = 4'hc;
  localparam logic [0:0] CTRL_RST   = 1'h1;                  // sampling on
  localparam int         CTRL_EN    = 0;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // four displayed patterns, updated as one unit
  typedef struct packed {
    logic [3:0][7:0] pat;
  } vmsc_disp_type;

  localparam vmsc_disp_type DISP_RST = '{pat: {SEG_BLANK, SEG_0 | SEG_DP,
                                               SEG_0, SEG_0}};

endpackage

// ---- bench/vmsc_adc_model.sv ----
// vmsc_adc_model: behavioural converter standing beside the voltmeter
// assumes adc_start is a one-cycle pulse from the block on mclk
`timescale 1ns/10ps
`default_nettype none
module vmsc_adc_model (
  input  wire logic        mclk,       // system clock
  input  wire logic        rst,        // async reset, high
  input  wire logic        adc_start,  // conversion start pulse
  input  wire logic [15:0] word,       // word to return, set by bench
  input  wire logic [9:0]  lat,        // cycles from start to done
  output logic             adc_done,   // one-cycle done pulse
  output logic [15:0]      adc_result  // left-justified result word
);
  logic       busy;
  logic [9:0] cnt;

  // result is junk while converting, so it toggles every cycle
  always_ff @(posedge mclk or posedge rst)
    if (rst)
    begin
      busy       <= 1'b0;
      cnt        <= 10'h000;
      adc_done   <= 1'b0;
      adc_result <= 16'h0000;
    end
    else
    begin
      adc_done <= 1'b0;
      if (adc_start)
      begin
        busy       <= 1'b1;
        cnt        <= 10'h001;
        adc_result <= ~adc_result;
      end
      else if (busy)
      begin
        cnt <= cnt + 10'h001;
        if (cnt >= lat)
        begin
          busy       <= 1'b0;
          adc_done   <= 1'b1;
          adc_result <= word;
        end
        else
          adc_result <= ~adc_result;
      end
    end
endmodule
`default_nettype wire

// ---- bench/vmsc_tb_top.sv ----
// voltmeter testbench: AXI4-Lite master, converter model, display watch
// assumes short sample and scan counts set through the top's parameters
`timescale 1ns/10ps
`default_nettype none
module voltmeter_sample_and_led_scan_tb_top;
  import vmsc_pkg::*;
  localparam int SMP = 200;  // cycles per sample tick
  localparam int SCN = 16;   // cycles per scan step
  logic        mclk = 1'b0, rst = 1'b1;
  logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'h0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic        s_axi_rvalid, adc_start, adc_done;
  logic [1:0]  s_axi_bresp, s_axi_rresp, digit_select;
  logic [2:0]  analog_channel;
  logic [15:0] adc_result, word = 16'h0000;
  logic [9:0]  lat = 10'd10;
  logic [7:0]  segment_out;
  logic [7:0]  seg_t [10] = '{8'h3f, 8'h06, 8'h5b, 8'h4f, 8'h66,
                              8'h6d, 8'h7d, 8'h27, 8'h7f, 8'h6f};
  int          errors = 0, checks_done = 0, cyc = 0;

  vmsc_top #(.SAMPLE_N(SMP), .SCAN_N(SCN)) vmsc_top_i (
    .mclk(mclk), .rst(rst), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .adc_start(adc_start), .analog_channel(analog_channel),
    .adc_done(adc_done), .adc_result(adc_result),
    .segment_out(segment_out), .digit_select(digit_select));
  vmsc_adc_model vmsc_adc_model_i (
    .mclk(mclk), .rst(rst), .adc_start(adc_start), .word(word),
    .lat(lat), .adc_done(adc_done), .adc_result(adc_result));

  // 200 MHz clock and a cycle count for interval checks
  always #2.5 mclk = ~mclk;
  always @(posedge mclk) cyc <= cyc + 1;

  task automatic end_of_test;
    $display("errors %0d checks %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // ready and valid sampled at the falling edge, so no race at the rise
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d,
                        input logic [3:0] st);
    logic at, wt, bt;
    logic [1:0] r;
    bt = 1'b0;
    @(posedge mclk);
    s_axi_awaddr  <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= st;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    while (!bt)
    begin
      @(negedge mclk);
      at = s_axi_awready;
      wt = s_axi_wready;
      bt = (s_axi_bvalid === 1'b1);
      r  = s_axi_bresp;
      @(posedge mclk);
      if (at === 1'b1)
        s_axi_awvalid <= 1'b0;
      if (wt === 1'b1)
        s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    check(r, RESP_OKAY);
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
    logic at, rt;
    logic [31:0] d;
    logic [1:0]  r;
    rt = 1'b0;
    @(posedge mclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    while (!rt)
    begin
      @(negedge mclk);
      at = s_axi_arready;
      rt = (s_axi_rvalid === 1'b1);
      d  = s_axi_rdata;
      r  = s_axi_rresp;
      @(posedge mclk);
      if (at === 1'b1)
        s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    check(r, RESP_OKAY);
    check(d, exp);
  endtask

  task automatic wait_start;
    do @(negedge mclk); while (adc_start !== 1'b1);
  endtask

  task automatic wait_done;
    do @(negedge mclk); while (adc_done !== 1'b1);
  endtask

  // hundredths split into digits; top digit is always blank in range
  function automatic logic [31:0] exp_pats(input int code);
    int h;
    h = code * 330 / 1024;
    return {8'h00, seg_t[h / 100] | 8'h80, seg_t[(h / 10) % 10],
            seg_t[h % 10]};
  endfunction

  task automatic t_reset;
    @(posedge mclk);
    @(negedge mclk);
    check(segment_out, 8'h3f);
    check(digit_select, 2'h0);
    check(analog_channel, 3'h0);
    rd_chk(REG_DIGITS, 32'h00bf3f3f);
    rd_chk(REG_CTRL, 32'h1);
  endtask

  task automatic t_slow;
    int t0;
    wait_start;
    t0 = cyc;
    wait_start;
    check(cyc - t0, SMP);
    wait_done;
    @(posedge mclk) lat <= 10'd300;
    wait_start;
    t0 = cyc;
    wait_start;
    check(cyc - t0, 2 * SMP);
    wait_done;
    @(posedge mclk) lat <= 10'd10;
  endtask

  // a finished result is held back until the following tick
  task automatic t_codes;
    logic [15:0] prev, w;
    logic [9:0]  codes [4] = '{10'd523, 10'd1023, 10'd466, 10'd146};
    prev = 16'h0000;
    for (int i = 0; i < 4; i++)
    begin
      w = {codes[i], 6'h00};
      wait_done;
      @(posedge mclk) word <= w;
      wait_start;
      wait_done;
      rd_chk(REG_RESULT, {16'h0000, prev});
      wait_start;
      repeat (5) @(negedge mclk);
      rd_chk(REG_RESULT, {16'h0000, w});
      rd_chk(REG_VOLTS, codes[i] * 330 / 1024);
      rd_chk(REG_DIGITS, exp_pats(codes[i]));
      prev = w;
    end
  endtask

  task automatic t_scan;
    logic [31:0] pats;
    logic [1:0]  s, nx;
    int          t0;
    pats = exp_pats(146);
    @(negedge mclk);
    s = digit_select;
    for (int k = 0; k < 5; k++)
    begin
      while (digit_select === s) @(negedge mclk);
      if (k > 0)
        check(cyc - t0, SCN);
      nx = s + 2'h1;
      check(digit_select, nx);
      check(segment_out, pats[8 * digit_select +: 8]);
      s  = digit_select;
      t0 = cyc;
    end
  endtask

  task automatic t_ctrl;
    int n;
    n = 0;
    // enable bit sits in the lowest byte lane; a write without it is dropped
    axi_wr(REG_CTRL, 32'h0, 4'he);
    rd_chk(REG_CTRL, 32'h1);
    axi_wr(REG_CTRL, 32'h0, 4'hf);
    rd_chk(REG_CTRL, 32'h0);
    repeat (2 * SMP + 10)
    begin
      @(negedge mclk);
      if (adc_start === 1'b1)
        n++;
    end
    check(n, 0);
    axi_wr(REG_RESULT, 32'h00001234, 4'hf);
    rd_chk(REG_RESULT, 32'h00002480);
    axi_wr(REG_CTRL, 32'h1, 4'hf);
    wait_start;
  endtask

  initial
  begin
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    t_reset;
    t_slow;
    t_codes;
    t_scan;
    t_ctrl;
    end_of_test;
  end

  // cuts a hang short well past the expected few thousand cycles
  initial
  begin
    #100_000;
    errors++;
    end_of_test;
  end
endmodule
`default_nettype wire
